// ### logic/mcs_mode_ctrl.sv
module mcs_mode_ctrl #(
    parameter int unsigned SEC_CYCLES = mcs_pkg::SECOND_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Configuration
    input wire mcs_pkg::mcs_starter_t i_starter_type,
    input wire mcs_pkg::mcs_ain_range_t i_ain_range,
    input wire logic [mcs_pkg::AIN_W-1:0] i_ain_offset,
    input wire logic [mcs_pkg::AIN_W-1:0] i_ain_span,
    input wire logic [mcs_pkg::SEC_W-1:0] i_uts_time_s,
    input wire logic [mcs_pkg::CUR_W-1:0] i_motor_full_load_current,
    input wire logic i_bypass_confirm_en,
    // Control pins
    input wire logic i_start,
    input wire logic i_stop,
    input wire logic i_bypass_delta_contactor_fb,
    // Internal measurements and soft-start logic
    input wire logic [mcs_pkg::AIN_W-1:0] i_ain_raw,
    input wire logic [mcs_pkg::CUR_W-1:0] i_meas_current,
    input wire logic i_at_speed,
    input wire logic i_fault,
    input wire logic [mcs_pkg::PCT_W-1:0] i_soft_firing,
    // Relays and contactors
    output logic o_run_relay,
    output logic o_up_to_speed_relay,
    output logic o_bypass_drive,
    // SCR stack
    output logic o_scr_gate_en,
    output logic [mcs_pkg::PCT_W-1:0] o_firing,
    output logic [mcs_pkg::CUR_W-1:0] o_current_cmd,
    // Analog output and status
    output logic [mcs_pkg::PCT_W-1:0] o_analog_out,
    output logic o_bad_scr_prot_en,
    output logic o_stack_ovl_prot_en,
    output logic o_bypass_fault,
    output logic o_running
);
    import mcs_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACCEL,
        ST_AT_SPEED,
        ST_FAULT
    } mcs_state_t;

    localparam logic [TICK_W-1:0] LOOP_LAST = TICK_W'(LOOP_CYCLES - 1);

    // Contactor-only starters: the SCR stack never conducts
    function automatic logic mcs_electromech(input mcs_starter_t m);
        return (m == MCS_WYE_OPEN) || (m == MCS_WYE_CLOSED) || (m == MCS_ATL);
    endfunction

    function automatic logic mcs_active(input mcs_state_t s);
        return (s == ST_ACCEL) || (s == ST_AT_SPEED);
    endfunction

    mcs_state_t state;
    mcs_state_t next_state;
    mcs_starter_t mode;
    logic [1:0] start_sync;
    logic [1:0] stop_sync;
    logic [1:0] fb_sync;
    logic start_s;
    logic stop_s;
    logic fb_s;
    logic wye;
    logic trip;
    logic at_speed_cond;
    logic bypass_bad;
    logic fb_seen;
    logic [TICK_W-1:0] loop_cnt;
    logic loop_tick;
    logic [CUR_W-1:0] next_cmd;

    mcs_ref_if ref_io();
    mcs_tmr_if uts_tmr();
    mcs_tmr_if cfm_tmr();

    mcs_ref_scaler u_scaler (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .ref_io(ref_io)
    );

    mcs_sec_timer #(.SEC_CYCLES(SEC_CYCLES)) u_uts_timer (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .tmr(uts_tmr)
    );

    mcs_sec_timer #(.SEC_CYCLES(SEC_CYCLES)) u_confirm_timer (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .tmr(cfm_tmr)
    );

    // Pin synchronisers
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            start_sync <= '0;
            stop_sync <= '0;
            fb_sync <= '0;
        end else begin
            start_sync <= {start_sync[0], i_start};
            stop_sync <= {stop_sync[0], i_stop};
            fb_sync <= {fb_sync[0], i_bypass_delta_contactor_fb};
        end
    end

    assign start_s = start_sync[1];
    assign stop_s = stop_sync[1];
    assign fb_s = fb_sync[1];

    assign ref_io.raw = i_ain_raw;
    assign ref_io.offset = i_ain_offset;
    assign ref_io.span = i_ain_span;
    assign ref_io.range = i_ain_range;

    assign wye = (mode == MCS_WYE_OPEN) || (mode == MCS_WYE_CLOSED);

    // Changeover timer runs from start while in wye-delta
    assign uts_tmr.run = wye && (state == ST_ACCEL || state == ST_AT_SPEED);
    assign uts_tmr.limit = i_uts_time_s;

    // Confirm window opens when the delta relay closes
    assign cfm_tmr.run = (mode == MCS_WYE_CLOSED) && i_bypass_confirm_en
                         && o_up_to_speed_relay;
    assign cfm_tmr.limit = BYPASS_CONFIRM_S;

    assign bypass_bad = cfm_tmr.done && !fb_s;
    assign trip = i_fault || bypass_bad || o_bypass_fault;

    always_comb begin
        case (mode)
            MCS_WYE_OPEN, MCS_WYE_CLOSED: at_speed_cond = uts_tmr.done;
            default: at_speed_cond = i_at_speed;
        endcase
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_s && !stop_s && !i_fault) begin
                    next_state = ST_ACCEL;
                end
            end
            ST_ACCEL: begin
                if (trip) begin
                    next_state = ST_FAULT;
                end else if (stop_s || !start_s) begin
                    next_state = ST_IDLE;
                end else if (at_speed_cond) begin
                    next_state = ST_AT_SPEED;
                end
            end
            ST_AT_SPEED: begin
                if (trip) begin
                    next_state = ST_FAULT;
                end else if (stop_s || !start_s) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                if (!start_s) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Mode latched while stopped so a running start never changes type
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mode <= MCS_SOFT;
        end else if (state == ST_IDLE) begin
            mode <= i_starter_type;
        end
    end

    // Bypass supervision: missing or lost feedback trips the start
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            fb_seen <= 1'b0;
            o_bypass_fault <= 1'b0;
        end else if (state == ST_IDLE && next_state == ST_ACCEL) begin
            fb_seen <= 1'b0;
            o_bypass_fault <= 1'b0;
        end else if (cfm_tmr.run) begin
            fb_seen <= fb_seen || fb_s;
            if (bypass_bad || (fb_seen && !fb_s)) begin
                o_bypass_fault <= 1'b1;
            end
        end
    end

    // Motor energized while accelerating or at speed
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_running <= 1'b0;
        end else begin
            o_running <= mcs_active(next_state);
        end
    end

    // Run relay with start in every mode
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_run_relay <= 1'b0;
        end else begin
            o_run_relay <= mcs_active(next_state);
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_up_to_speed_relay <= 1'b0;
        end else begin
            o_up_to_speed_relay <= (next_state == ST_AT_SPEED)
                                   && (wye || mode == MCS_ATL
                                       || mode == MCS_SOFT);
        end
    end

    // Only a bypassed soft starter closes the bypass
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_bypass_drive <= 1'b0;
        end else begin
            o_bypass_drive <= (next_state == ST_AT_SPEED) && (mode == MCS_SOFT);
        end
    end

    // Electromechanical modes mask the SCR-stack protections
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_bad_scr_prot_en <= 1'b1;
        end else begin
            o_bad_scr_prot_en <= !mcs_electromech(mode);
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_stack_ovl_prot_en <= 1'b1;
        end else begin
            o_stack_ovl_prot_en <= !mcs_electromech(mode);
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            loop_cnt <= '0;
        end else if (loop_cnt == LOOP_LAST) begin
            loop_cnt <= '0;
        end else begin
            loop_cnt <= loop_cnt + 1'b1;
        end
    end

    assign loop_tick = (loop_cnt == LOOP_LAST);
    assign next_cmd = mcs_apply(ref_io.pct, i_motor_full_load_current);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_current_cmd <= '0;
        end else if (mode == MCS_CURR_FOLLOW && o_running) begin
            o_current_cmd <= next_cmd;
        end else begin
            o_current_cmd <= '0;
        end
    end

    // SCR gating: only the stack-driven modes conduct
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_scr_gate_en <= 1'b0;
        end else if (!o_running) begin
            o_scr_gate_en <= 1'b0;
        end else begin
            case (mode)
                MCS_PHASE, MCS_CURR_FOLLOW, MCS_SOFT: o_scr_gate_en <= 1'b1;
                default: o_scr_gate_en <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_firing <= PCT_ZERO;
        end else if (!o_running) begin
            o_firing <= PCT_ZERO;
        end else begin
            case (mode)
                MCS_PHASE: begin
                    o_firing <= ref_io.pct;
                end
                MCS_CURR_FOLLOW: begin
                    if (o_current_cmd == '0) begin
                        o_firing <= PCT_ZERO;
                    end else if (loop_tick) begin
                        if (i_meas_current < o_current_cmd && o_firing < PCT_FULL) begin
                            o_firing <= o_firing + FIRING_STEP;
                        end else if (i_meas_current > o_current_cmd
                                     && o_firing > PCT_ZERO) begin
                            o_firing <= o_firing - FIRING_STEP;
                        end
                    end
                end
                MCS_SOFT: begin
                    o_firing <= i_soft_firing;
                end
                default: begin
                    // Wye-delta and full voltage: ramp inputs never reach the gates
                    o_firing <= PCT_ZERO;
                end
            endcase
        end
    end

    // Firing mirrored for slave starters
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_analog_out <= PCT_ZERO;
        end else begin
            o_analog_out <= o_firing;
        end
    end
endmodule

// ### logic/mcs_pkg.sv
// Behaviour
// - Starter-type setting selects the operating mode
// - Wye-delta masks bad SCR and stack overload
// - Up-to-speed time sets wye-to-delta changeover
// - Open and closed transition wye-delta supported
// - Wye-delta uses run and up-to-speed relays
// - Closed transition supervises bypass contactor feedback
// - Phase control fires SCRs open loop
// - Phase control: 0% off, 100% full voltage
// - Offset and span scale the analog input
// - Input accepts 0-10V, 0-20mA, 4-20mA
// - Phase control never drives the bypass contactor
// - Analog output carries 0-100% firing for slaves
// - Current follower regulates current in closed loop
// - Current follower start: run relay, gate SCRs
// - Current follower: 100% equals full-load current
// - Across-the-line start energizes the run relay
// - Across-the-line at speed energizes up-to-speed relay
// - Across-the-line masks bad SCR and stack overload
// - Across-the-line ignores ramp, kick and decel
// - Across-the-line holds SCR gates disabled
package mcs_pkg;
    typedef enum logic [2:0] {
        MCS_SOFT,
        MCS_WYE_OPEN,
        MCS_WYE_CLOSED,
        MCS_PHASE,
        MCS_CURR_FOLLOW,
        MCS_ATL
    } mcs_starter_t;

    typedef enum logic [1:0] {
        MCS_AIN_0_10V,
        MCS_AIN_0_20MA,
        MCS_AIN_4_20MA
    } mcs_ain_range_t;

    localparam int AIN_W = 12;
    localparam int PCT_W = 10;
    localparam int CUR_W = 16;
    localparam int SEC_W = 8;
    localparam int TICK_W = 32;

    localparam int CLK_PERIOD_NS = 4;
    localparam int SECOND_NS = 1_000_000_000;
    localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
    localparam int LOOP_PERIOD_NS = 1000;
    localparam int LOOP_CYCLES = LOOP_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [SEC_W-1:0] BYPASS_CONFIRM_S = 8'h02;

    localparam logic [PCT_W-1:0] PCT_ZERO = 10'h000;
    localparam logic [PCT_W-1:0] PCT_FULL = 10'h3E8;
    localparam logic [PCT_W-1:0] FIRING_STEP = 10'h001;
    localparam logic [AIN_W-1:0] ADC_LIVE_ZERO = 12'h333;
    localparam logic [AIN_W-1:0] ADC_MAX = 12'hFFF;

    // Linear map of num/den onto 0..PCT_FULL, clamped
    function automatic logic [PCT_W-1:0] mcs_scale(input logic [AIN_W-1:0] num,
                                                   input logic [AIN_W-1:0] den);
        logic [AIN_W+PCT_W-1:0] q;
        q = '0;
        if (den == '0) begin
            return PCT_ZERO;
        end
        q = ({10'h000, num} * {12'h000, PCT_FULL}) / {10'h000, den};
        if (q > {12'h000, PCT_FULL}) begin
            return PCT_FULL;
        end
        return q[PCT_W-1:0];
    endfunction

    // Fraction pct/PCT_FULL of a full-scale value
    function automatic logic [CUR_W-1:0] mcs_apply(input logic [PCT_W-1:0] pct,
                                                   input logic [CUR_W-1:0] full);
        logic [CUR_W+PCT_W-1:0] p;
        p = ({16'h0000, pct} * {10'h000, full}) / {16'h0000, PCT_FULL};
        return p[CUR_W-1:0];
    endfunction
endpackage

// ### logic/mcs_if.sv
interface mcs_ref_if;
    import mcs_pkg::*;
    logic [AIN_W-1:0] raw;
    logic [AIN_W-1:0] offset;
    logic [AIN_W-1:0] span;
    mcs_ain_range_t range;
    logic [PCT_W-1:0] pct;
    modport scl(input raw, input offset, input span, input range, output pct);
    modport src(output raw, output offset, output span, output range, input pct);
endinterface

interface mcs_tmr_if;
    import mcs_pkg::*;
    logic run;
    logic [SEC_W-1:0] limit;
    logic done;
    modport cnt(input run, input limit, output done);
    modport ctl(output run, output limit, input done);
endinterface

// ### logic/mcs_ref_scaler.sv
module mcs_ref_scaler (
    input wire logic i_clk,
    input wire logic i_rstn,
    mcs_ref_if.scl ref_io
);
    import mcs_pkg::*;

    logic [AIN_W:0] eff_offset;
    logic [AIN_W-1:0] zero_pt;
    logic [AIN_W-1:0] diff;

    // Live zero of a 4-20mA source added to the user offset
    always_comb begin
        eff_offset = {1'b0, ref_io.offset};
        if (ref_io.range == MCS_AIN_4_20MA) begin
            eff_offset = {1'b0, ref_io.offset} + {1'b0, ADC_LIVE_ZERO};
        end
        zero_pt = eff_offset[AIN_W] ? ADC_MAX : eff_offset[AIN_W-1:0];
        diff = (ref_io.raw > zero_pt) ? (ref_io.raw - zero_pt) : '0;
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ref_io.pct <= PCT_ZERO;
        end else begin
            ref_io.pct <= mcs_scale(diff, ref_io.span);
        end
    end
endmodule

// ### logic/mcs_sec_timer.sv
module mcs_sec_timer #(
    parameter int unsigned SEC_CYCLES = mcs_pkg::SECOND_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    mcs_tmr_if.cnt tmr
);
    import mcs_pkg::*;

    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SEC_CYCLES - 1);

    logic [TICK_W-1:0] tick;
    logic [SEC_W-1:0] secs;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tick <= '0;
        end else if (!tmr.run || tick == TICK_LAST) begin
            tick <= '0;
        end else begin
            tick <= tick + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            secs <= '0;
        end else if (!tmr.run) begin
            secs <= '0;
        end else if (tick == TICK_LAST && secs != tmr.limit) begin
            secs <= secs + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tmr.done <= 1'b0;
        end else begin
            tmr.done <= tmr.run && (secs == tmr.limit);
        end
    end
endmodule

// ### verification/mcs_plant_model.sv
module mcs_plant_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // From the controller, and the feedback mode from the bench
    input wire logic i_run_relay,
    input wire logic i_up_to_speed_relay,
    input wire logic i_scr_gate_en,
    input wire logic [mcs_pkg::PCT_W-1:0] i_firing,
    input wire logic [1:0] i_fb_mode,
    // To the controller
    output logic o_contactor_fb,
    output logic [mcs_pkg::CUR_W-1:0] o_meas_current,
    output logic o_at_speed
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] run_cnt;
    logic [3:0] fb_cnt;
    // Motor reaches speed a while after the main contactor closes
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn || !i_run_relay) run_cnt <= 8'h00;
        else if (run_cnt != 8'hFF) run_cnt <= run_cnt + 8'h01;
    end
    assign o_at_speed = run_cnt > 8'h1E;
    // Bypass contactor closes after the delta relay: 0 fast, 1 slow, 2 never
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn || !i_up_to_speed_relay) fb_cnt <= 4'h0;
        else if (fb_cnt != 4'hF) fb_cnt <= fb_cnt + 4'h1;
    end
    assign o_contactor_fb = i_fb_mode == 2'h0 ? fb_cnt > 4'h2
                            : i_fb_mode == 2'h1 && fb_cnt == 4'hF;
    // Stack current follows firing only while gated
    assign o_meas_current = i_scr_gate_en ? {i_firing, 6'h00} : 16'h0000;
endmodule

// ### verification/mcs_mode_ctrl_props.sv
module mcs_mode_ctrl_props (
    // Clock, reset and inputs
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire mcs_pkg::mcs_starter_t i_starter_type,
    input wire logic i_start,
    input wire logic i_stop,
    input wire logic i_fault,
    input wire logic i_at_speed,
    // Outputs
    input wire logic o_run_relay,
    input wire logic o_up_to_speed_relay,
    input wire logic o_bypass_drive,
    input wire logic o_scr_gate_en,
    input wire logic [mcs_pkg::PCT_W-1:0] o_firing,
    input wire logic o_bad_scr_prot_en,
    input wire logic o_stack_ovl_prot_en,
    input wire logic o_bypass_fault,
    input wire logic o_running
);
    import mcs_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    wire across_the_line_mode = i_starter_type == MCS_ATL;
    wire wye = i_starter_type == MCS_WYE_OPEN || i_starter_type == MCS_WYE_CLOSED;
    wire phs = i_starter_type == MCS_PHASE;
    wire fol = i_starter_type == MCS_CURR_FOLLOW;
    AST_ATL_GATES: assert property (o_running && across_the_line_mode |-> !o_scr_gate_en && o_firing == '0)
        else $error("gates on in full-voltage mode");
    AST_MASK: assert property (o_running && $past(o_running) && (across_the_line_mode || wye) |->
        !o_bad_scr_prot_en && !o_stack_ovl_prot_en) else $error("protection not masked");
    AST_PHASE_BYP: assert property (o_running && phs |-> !o_bypass_drive)
        else $error("bypass driven in phase mode");
    AST_RUN_CAUSE: assert property ($rose(o_run_relay) |->
        $past(i_start, 3) && !$past(i_stop, 3)) else $error("run relay without start");
    AST_STOP_DROP: assert property ($fell(i_start) |-> ##[1:3] !o_run_relay)
        else $error("run relay held after start drop");
    AST_FAULT_DROP: assert property (i_fault |-> ##[1:4] !o_run_relay)
        else $error("run relay held in fault");
    AST_STOP_GATES: assert property ($fell(o_running) |=> !o_scr_gate_en && o_firing == '0)
        else $error("gates on after stop");
    AST_ATL_UTS: assert property ($rose(o_up_to_speed_relay) && across_the_line_mode |-> $past(i_at_speed))
        else $error("speed relay without speed");
    AST_RUN_ONLY: assert property (o_running && (phs || fol) |-> !o_up_to_speed_relay)
        else $error("speed relay in phase or follower");
    AST_FOL_GATE: assert property (o_running && $past(o_running) && fol |-> o_scr_gate_en)
        else $error("follower not gating");
    AST_BYP_TRIP: assert property ($rose(o_bypass_fault) |-> ##[0:1] !o_run_relay)
        else $error("relays held after bypass fault");
    cover property ($rose(o_up_to_speed_relay) && across_the_line_mode);
    cover property ($rose(o_bypass_fault));
    cover property (o_running && phs);
    cover property (o_running && fol);
endmodule

bind mcs_mode_ctrl mcs_mode_ctrl_props mcs_mode_ctrl_props_inst (
    .i_clk, .i_rstn, .i_starter_type, .i_start, .i_stop, .i_fault, .i_at_speed, .o_run_relay,
    .o_up_to_speed_relay, .o_bypass_drive, .o_scr_gate_en, .o_firing, .o_bad_scr_prot_en,
    .o_stack_ovl_prot_en, .o_bypass_fault, .o_running
);

// ### verification/mcs_mode_ctrl_bench.sv
module mcs_mode_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import mcs_pkg::*;
    localparam int unsigned SC = 20;
    logic i_clk, i_rstn, i_bypass_confirm_en, i_start, i_stop, i_fault, fb, at_spd;
    logic o_run_relay, o_up_to_speed_relay, o_bypass_drive, o_scr_gate_en, o_running;
    logic o_bad_scr_prot_en, o_stack_ovl_prot_en, o_bypass_fault;
    mcs_starter_t i_starter_type;
    mcs_ain_range_t i_ain_range;
    logic [AIN_W-1:0] i_ain_offset, i_ain_span, i_ain_raw;
    logic [PCT_W-1:0] i_soft_firing, o_firing, o_analog_out;
    logic [CUR_W-1:0] i_motor_full_load_current, o_current_cmd, meas;
    logic [SEC_W-1:0] i_uts_time_s;
    logic [1:0] fb_mode;
    logic [31:0] seed, e;
    int err_total, n_checks, n;
    mcs_mode_ctrl #(.SEC_CYCLES(SC)) mcs_mode_ctrl_inst (
        .i_clk, .i_rstn, .i_starter_type, .i_ain_range, .i_ain_offset, .i_ain_span,
        .i_uts_time_s, .i_motor_full_load_current, .i_bypass_confirm_en, .i_start, .i_stop,
        .i_bypass_delta_contactor_fb(fb), .i_ain_raw, .i_meas_current(meas),
        .i_at_speed(at_spd), .i_fault, .i_soft_firing, .o_run_relay, .o_up_to_speed_relay,
        .o_bypass_drive, .o_scr_gate_en, .o_firing, .o_current_cmd, .o_analog_out,
        .o_bad_scr_prot_en, .o_stack_ovl_prot_en, .o_bypass_fault, .o_running
    );
    mcs_plant_model mcs_plant_model_inst (
        .i_clk, .i_rstn, .i_run_relay(o_run_relay), .i_up_to_speed_relay(o_up_to_speed_relay),
        .i_scr_gate_en(o_scr_gate_en), .i_firing(o_firing), .i_fb_mode(fb_mode),
        .o_contactor_fb(fb), .o_meas_current(meas), .o_at_speed(at_spd)
    );
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Percent of full scale, 0..1000, from raw counts
    function automatic logic [31:0] exp_pct(logic [31:0] raw, logic [31:0] off, logic [31:0] sp,
                                            logic lz);
        logic [31:0] z;
        logic [31:0] q;
        z = off + (lz ? 32'h333 : 32'h0);
        if (sp == 32'h0 || raw <= z) return 32'h0;
        q = (raw - z) * 32'h3E8 / sp;
        return q > 32'h3E8 ? 32'h3E8 : q;
    endfunction
    task automatic tick(input int k);
        repeat (k) @(negedge i_clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic wait_hi(ref logic s, input int lim, output int cnt);
        cnt = 0;
        while (s !== 1'b1 && cnt < lim) begin
            tick(1);
            cnt++;
        end
    endtask
    task automatic go(input mcs_starter_t t);
        i_starter_type = t;
        tick(2);
        i_start = 1'b1;
        wait_hi(o_running, 20, n);
        chk("running", o_running, 1'b1);
    endtask
    task automatic halt(input logic by_stop);
        if (by_stop) i_stop = 1'b1;
        else i_start = 1'b0;
        tick(6);
        chk("run off", o_run_relay, 1'b0);
        chk("uts off", o_up_to_speed_relay, 1'b0);
        i_stop = 1'b0;
        i_start = 1'b0;
        tick(2);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    initial begin
        #400us;
        err_total++;
        end_sim();
    end
    initial begin
        seed = 32'hAF4B;
        {i_rstn, i_start, i_stop, i_fault, i_bypass_confirm_en} = 5'h00;
        {i_ain_offset, i_ain_span, i_ain_raw, i_soft_firing} = '0;
        {i_motor_full_load_current, i_uts_time_s, fb_mode} = '0;
        i_starter_type = MCS_SOFT;
        i_ain_range = MCS_AIN_0_10V;
        tick(10);
        i_rstn = 1'b1;
        tick(2);
        chk("prot reset", {o_bad_scr_prot_en, o_stack_ovl_prot_en, o_run_relay}, 3'h6);
        i_soft_firing = 10'(xs());
        go(MCS_SOFT);
        tick(2);
        chk("soft firing", {o_scr_gate_en, o_firing}, {1'b1, i_soft_firing});
        wait_hi(o_bypass_drive, 100, n);
        chk("soft bypass", {o_up_to_speed_relay, o_bypass_drive}, 2'h3);
        chk("prot soft", {o_bad_scr_prot_en, o_stack_ovl_prot_en}, 2'h3);
        halt(1'b0);
        go(MCS_ATL);
        tick(2);
        chk("prot atl", {o_bad_scr_prot_en, o_stack_ovl_prot_en}, 2'h0);
        chk("run atl", o_run_relay, 1'b1);
        wait_hi(o_up_to_speed_relay, 100, n);
        chk("uts atl", o_up_to_speed_relay, 1'b1);
        chk("gate atl", {o_scr_gate_en, o_firing}, 11'h000);
        halt(1'b1);
        i_uts_time_s = 8'(1 + xs() % 3);
        go(MCS_WYE_OPEN);
        wait_hi(o_up_to_speed_relay, 200, n);
        chk("uts time", n + 3 >= i_uts_time_s * SC && n <= i_uts_time_s * SC + 6, 1'b1);
        chk("prot wye", {o_bad_scr_prot_en, o_stack_ovl_prot_en}, 2'h0);
        chk("run wye", o_run_relay, 1'b1);
        halt(1'b0);
        i_bypass_confirm_en = 1'b1;
        for (int m = 0; m < 3; m++) begin
            fb_mode = 2'(m);
            go(MCS_WYE_CLOSED);
            wait_hi(o_bypass_fault, 40 + (3 + i_uts_time_s) * SC, n);
            chk("bypass fault", o_bypass_fault, m == 2);
            chk("uts closed", o_up_to_speed_relay, m != 2);
            halt(1'b0);
        end
        go(MCS_PHASE);
        for (int k = 0; k < 12; k++) begin
            i_ain_range = mcs_ain_range_t'(k % 3);
            i_ain_offset = 12'(xs() % 32'h100);
            i_ain_span = k == 1 ? 12'h010 : 12'(32'h40 + xs() % 32'hC00);
            i_ain_raw = k == 0 ? 12'h000 : k == 1 ? 12'hFFF :
                        k == 2 ? i_ain_offset + 12'h333 + i_ain_span : 12'(xs());
            tick(4);
            e = exp_pct(i_ain_raw, i_ain_offset, i_ain_span, i_ain_range == MCS_AIN_4_20MA);
            chk("firing", o_firing, e);
            chk("analog out", o_analog_out, e);
            chk("bypass", o_bypass_drive, 1'b0);
        end
        i_fault = 1'b1;
        tick(5);
        chk("trip", o_run_relay, 1'b0);
        i_fault = 1'b0;
        tick(6);
        chk("no restart", o_running, 1'b0);
        halt(1'b0);
        go(MCS_CURR_FOLLOW);
        for (int k = 0; k < 6; k++) begin
            i_motor_full_load_current = 16'(xs());
            i_ain_raw = k == 0 ? 12'h000 : 12'(xs());
            tick(4);
            e = exp_pct(i_ain_raw, i_ain_offset, i_ain_span, i_ain_range == MCS_AIN_4_20MA);
            chk("cmd", o_current_cmd, e * i_motor_full_load_current / 32'h3E8);
            chk("gate fol", o_scr_gate_en, 1'b1);
            chk("uts fol", o_up_to_speed_relay, 1'b0);
        end
        {i_motor_full_load_current, i_ain_raw, i_ain_offset} = {16'hFFFF, 12'hFFF, 12'h000};
        tick(700);
        chk("loop rises", o_firing != 10'h000, 1'b1);
        halt(1'b0);
        chk("gate stop", {o_scr_gate_en, o_firing}, 11'h000);
        end_sim();
    end
endmodule
